// ---- shared/ryac_defs.svh ----
// Purpose: Constants for the RTC year counter and alarm compare block.
// Assumes: 8-bit register port, one clock, byte-wide registers.
// Notes:   Offsets are register indices on the plain register port.
`ifndef RYAC_DEFS_SVH
`define RYAC_DEFS_SVH

// Register indices
`define RYAC_OFS_YEAR    4'h0
`define RYAC_OFS_SEC     4'h1
`define RYAC_OFS_MIN     4'h2
`define RYAC_OFS_HOUR    4'h3
`define RYAC_OFS_WKDAY   4'h4
`define RYAC_OFS_STATUS  4'h5
`define RYAC_OFS_MASK    4'h6

// Field positions
`define RYAC_EN_BIT      7
`define RYAC_FLD_SEC     0
`define RYAC_FLD_MIN     1
`define RYAC_FLD_HOUR    2
`define RYAC_FLD_WKDAY   3
`define RYAC_INT_ALARM   0
`define RYAC_INT_YEAR    1

// Reset values and digit limits
`define RYAC_EN_RST      4'h0
`define RYAC_INT_RST     2'h0
`define RYAC_BCD_MAX     4'h9

`endif

// ---- shared/ryac_pkg.sv ----
// Purpose: Types for the RTC year counter and alarm compare block.
// Assumes: Constants come from ryac_defs.svh.
// Notes:   Time and alarm sets travel as packed structs.
`default_nettype none
package ryac_pkg;
    typedef logic [7:0] ryac_byte_t;
    typedef logic [1:0] ryac_irq_t;

    // Current time from the neighbouring counters
    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [2:0] wkday;
    } ryac_time_s;

    // Alarm setting with one enable per field
    typedef struct packed {
        logic [3:0] en;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [2:0] wkday;
    } ryac_alarm_s;
endpackage
`default_nettype wire

// ---- core/ryac_match.sv ----
// Purpose: Compares enabled alarm fields against the time counters.
// Assumes: Inputs are BCD values from the same clock domain.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
`include "ryac_defs.svh"
module ryac_match
    import ryac_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire ryac_alarm_s alarm_i,
    input  wire ryac_time_s  time_i,
    output logic             match_o
);
    logic [3:0][6:0] alarm_val;
    logic [3:0][6:0] time_val;
    logic [3:0]      hit;

    // Widen the hour and weekday fields to the 7-bit size of sec and min
    assign alarm_val[`RYAC_FLD_SEC]   = alarm_i.sec;
    assign alarm_val[`RYAC_FLD_MIN]   = alarm_i.min;
    assign alarm_val[`RYAC_FLD_HOUR]  = {1'b0, alarm_i.hour};
    assign alarm_val[`RYAC_FLD_WKDAY] = {4'h0, alarm_i.wkday};
    assign time_val[`RYAC_FLD_SEC]    = time_i.sec;
    assign time_val[`RYAC_FLD_MIN]    = time_i.min;
    assign time_val[`RYAC_FLD_HOUR]   = {1'b0, time_i.hour};
    assign time_val[`RYAC_FLD_WKDAY]  = {4'h0, time_i.wkday};

    // A disabled field always counts as hit
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_fld
            assign hit[g] = ~alarm_i.en[g] | (alarm_val[g] == time_val[g]);
        end
    endgenerate

    // Needs at least one enabled field
    assign match_o = (|alarm_i.en) & (&hit);

    // Enabled differing seconds field blocks the match
    skip_field_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (alarm_i.en[0] && alarm_val[0] != time_val[0]) |-> !match_o)
        else $error("enabled mismatching field gave a match");
endmodule // ryac_match
`default_nettype wire

// ---- core/ryac_top.sv ----
// Purpose: BCD year counter with leap detect and alarm compare.
// Assumes: Time inputs and carries come from logic on clk_i.
// Notes:   Year and alarm values have no reset on purpose.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ryac_defs.svh"
module ryac_top
    import ryac_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       manual_reset_i,
    input  wire logic [3:0] addr_i,
    input  wire ryac_byte_t wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output ryac_byte_t      rdata_o,
    input  wire logic       month_carry_i,
    input  wire logic       count_start_i,
    input  wire ryac_time_s time_i,
    input  wire logic       time_update_i,
    output ryac_byte_t      year_o,
    output logic            leap_year_o,
    output logic            alarm_o,
    output logic            irq_o
);
    // Storage
    ryac_byte_t  year_ff;
    logic [3:0]  en_ff;
    logic [6:0]  sec_val_ff;
    logic [6:0]  min_val_ff;
    logic [5:0]  hour_val_ff;
    logic [2:0]  wk_val_ff;
    ryac_irq_t   status_ff;
    ryac_irq_t   mask_ff;
    ryac_byte_t  rdata_ff;
    logic        leap_ff;
    logic        alarm_ff;
    logic        irq_ff;
    logic        year_seen_ff;  // Set once software has loaded the year

    // Decode and next values
    logic        wr_year;
    logic        wr_sec;
    logic        wr_min;
    logic        wr_hour;
    logic        wr_wk;
    logic        wr_status;
    logic        wr_mask;
    logic        year_step;
    logic        units_wrap;
    logic [3:0]  step_units;
    logic [3:0]  step_tens;
    ryac_byte_t  nxt_year;
    logic [3:0]  nxt_en;
    logic        match;
    logic        alarm_evt;
    ryac_irq_t   irq_set;
    ryac_irq_t   irq_clr;
    ryac_irq_t   nxt_status;
    ryac_irq_t   nxt_mask;
    logic        nxt_irq;
    logic [1:0]  leap_sum;
    logic        nxt_leap;
    ryac_byte_t  rd_mux;
    ryac_alarm_s alarm_set;

    // Register port address decode
    assign wr_year   = wr_i && addr_i == `RYAC_OFS_YEAR;
    assign wr_sec    = wr_i && addr_i == `RYAC_OFS_SEC;
    assign wr_min    = wr_i && addr_i == `RYAC_OFS_MIN;
    assign wr_hour   = wr_i && addr_i == `RYAC_OFS_HOUR;
    assign wr_wk     = wr_i && addr_i == `RYAC_OFS_WKDAY;
    assign wr_status = wr_i && addr_i == `RYAC_OFS_STATUS;
    assign wr_mask   = wr_i && addr_i == `RYAC_OFS_MASK;

    // BCD year increment, units then tens
    assign year_step  = month_carry_i & count_start_i;
    assign units_wrap = year_ff[3:0] == `RYAC_BCD_MAX;
    assign step_units = units_wrap ? 4'h0 : year_ff[3:0] + 4'h1;
    assign step_tens  = !units_wrap ? year_ff[7:4] :
                        (year_ff[7:4] == `RYAC_BCD_MAX) ? 4'h0 :
                        year_ff[7:4] + 4'h1;

    // Software write wins over a carry
    assign nxt_year = wr_year   ? wdata_i :
                      year_step ? {step_tens, step_units} : year_ff;

    // Enable bits live in bit 7 of each alarm register
    assign nxt_en[`RYAC_FLD_SEC]   = wr_sec  ? wdata_i[`RYAC_EN_BIT] : en_ff[`RYAC_FLD_SEC];
    assign nxt_en[`RYAC_FLD_MIN]   = wr_min  ? wdata_i[`RYAC_EN_BIT] : en_ff[`RYAC_FLD_MIN];
    assign nxt_en[`RYAC_FLD_HOUR]  = wr_hour ? wdata_i[`RYAC_EN_BIT] : en_ff[`RYAC_FLD_HOUR];
    assign nxt_en[`RYAC_FLD_WKDAY] = wr_wk   ? wdata_i[`RYAC_EN_BIT] : en_ff[`RYAC_FLD_WKDAY];

    // Leap test: (10*tens + units) mod 4 equals (2*tens + units) mod 4
    assign leap_sum = year_ff[1:0] + {year_ff[4], 1'b0};
    assign nxt_leap = leap_sum == 2'h0;

    // Alarm compare, sampled when the counters update
    assign alarm_set = '{en: en_ff, sec: sec_val_ff, min: min_val_ff,
                         hour: hour_val_ff, wkday: wk_val_ff};
    assign alarm_evt = time_update_i & match;

    ryac_match u_match (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .alarm_i   (alarm_set),
        .time_i    (time_i),
        .match_o   (match)
    );

    // Sticky events; a set in the clear cycle survives
    assign irq_set[`RYAC_INT_ALARM] = alarm_evt;
    assign irq_set[`RYAC_INT_YEAR]  = year_step & ~wr_year; // A carry dropped by a write is no step
    assign irq_clr    = wr_status ? wdata_i[1:0] : 2'h0;
    assign nxt_status = manual_reset_i ? irq_set : (status_ff & ~irq_clr) | irq_set;
    assign nxt_mask   = manual_reset_i ? `RYAC_INT_RST : wr_mask ? wdata_i[1:0] : mask_ff;
    assign nxt_irq    = |(nxt_status & nxt_mask);

    // Read mux; fixed-zero bits and unmapped indices read zero
    assign rd_mux = (addr_i == `RYAC_OFS_YEAR)   ? year_ff :
                    (addr_i == `RYAC_OFS_SEC)    ? {en_ff[`RYAC_FLD_SEC], sec_val_ff} :
                    (addr_i == `RYAC_OFS_MIN)    ? {en_ff[`RYAC_FLD_MIN], min_val_ff} :
                    (addr_i == `RYAC_OFS_HOUR)   ? {en_ff[`RYAC_FLD_HOUR], 1'b0, hour_val_ff} :
                    (addr_i == `RYAC_OFS_WKDAY)  ? {en_ff[`RYAC_FLD_WKDAY], 4'h0, wk_val_ff} :
                    (addr_i == `RYAC_OFS_STATUS) ? {6'h00, status_ff} :
                    (addr_i == `RYAC_OFS_MASK)   ? {6'h00, mask_ff} : 8'h00;

    // Year and alarm values: no reset of any kind
    always_ff @(posedge clk_i) begin
        year_ff <= nxt_year;
        year_seen_ff <= year_seen_ff | wr_year;
        if (wr_sec) begin
            sec_val_ff <= wdata_i[6:0];
        end
        if (wr_min) begin
            min_val_ff <= wdata_i[6:0];
        end
        if (wr_hour) begin
            hour_val_ff <= wdata_i[5:0];
        end
        if (wr_wk) begin
            wk_val_ff <= wdata_i[2:0];
        end
    end

    // Enables clear only on power-on reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_ff <= `RYAC_EN_RST;
        end else begin
            en_ff <= nxt_en;
        end
    end

    // Interrupt, read data and output flags
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_ff <= `RYAC_INT_RST;
            mask_ff   <= `RYAC_INT_RST;
            irq_ff    <= 1'b0;
            rdata_ff  <= 8'h00;
            leap_ff   <= 1'b0;
            alarm_ff  <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            irq_ff    <= nxt_irq;
            rdata_ff  <= rd_i ? rd_mux : 8'h00;
            leap_ff   <= nxt_leap;
            alarm_ff  <= alarm_evt;
        end
    end

    assign rdata_o     = rdata_ff;
    assign year_o      = year_ff;
    assign leap_year_o = leap_ff;
    assign alarm_o     = alarm_ff;
    assign irq_o       = irq_ff;

    // Helper values watched only by the checks below
    logic [6:0] year_dec;
    assign year_dec = 7'(year_ff[7:4] * 4'ha) + 7'(year_ff[3:0]);

    // Single-cycle register port sequences
    sequence s_wr_sec;
        wr_i && addr_i == `RYAC_OFS_SEC;
    endsequence
    sequence s_rd_sec;
        rd_i && addr_i == `RYAC_OFS_SEC;
    endsequence
    sequence s_wr_min;
        wr_i && addr_i == `RYAC_OFS_MIN;
    endsequence
    sequence s_rd_min;
        rd_i && addr_i == `RYAC_OFS_MIN;
    endsequence

    // Units digit steps by one, tens holds
    year_step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (year_step && !wr_year && year_ff[3:0] < 4'h9)
        |=> (year_ff[3:0] == $past(year_ff[3:0]) + 4'h1) && $stable(year_ff[7:4]))
        else $error("year units did not step by one");

    // Ninety-nine wraps to zero
    year_wrap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (year_step && !wr_year && year_ff == 8'h99) |=> year_ff == 8'h00)
        else $error("year did not wrap from 99");

    // Units nine carries into tens
    year_carry_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (year_step && !wr_year && year_ff[3:0] == 4'h9 && year_ff[7:4] < 4'h9)
        |=> year_ff[3:0] == 4'h0 && year_ff[7:4] == $past(year_ff[7:4]) + 4'h1)
        else $error("year units did not carry into tens");

    // No carry, no write, no change, reset or not
    year_hold_a: assert property (@(posedge clk_i)
        (year_seen_ff && !year_step && !wr_year) |=> $stable(year_ff))
        else $error("year changed without carry or write");

    // Leap flag follows the decimal remainder
    leap_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (reset_n_i && year_seen_ff && $stable(year_ff))
        |=> leap_year_o == ($past(year_dec) % 7'd4 == 7'd0))
        else $error("leap flag disagrees with year");

    // Enables read zero in the first cycle after power-on
    enab_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !$past(reset_n_i) |-> en_ff == 4'h0)
        else $error("alarm enables not cleared by power-on reset");

    // Second alarm write then read returns the byte
    sec_layout_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (s_wr_sec ##1 s_rd_sec) |=> rdata_o == $past(wdata_i, 2))
        else $error("second alarm readback wrong");

    // Minute alarm write then read returns the byte
    min_layout_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (s_wr_min ##1 s_rd_min) |=> rdata_o == $past(wdata_i, 2))
        else $error("minute alarm readback wrong");

    // Hour alarm bit 6 reads zero
    hour_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `RYAC_OFS_HOUR) |=> rdata_o[6] == 1'b0 && rdata_o[5:0] == $past(hour_val_ff))
        else $error("hour alarm read layout wrong");

    // Weekday alarm bits 6 to 3 read zero
    wk_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `RYAC_OFS_WKDAY) |=> rdata_o[6:3] == 4'h0 && rdata_o[2:0] == $past(wk_val_ff))
        else $error("weekday alarm read layout wrong");

    // Full match on update gives a pulse and a sticky bit
    alarm_fire_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (time_update_i && match) |=> alarm_o && status_ff[`RYAC_INT_ALARM] ##1 !alarm_o || $past(alarm_evt))
        else $error("alarm not raised on full match");

    // No enables, no alarm
    no_enable_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (en_ff == 4'h0) |=> !alarm_o)
        else $error("alarm raised with no field enabled");

    // Enabled hour field that differs suppresses the alarm
    field_skip_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (time_update_i && en_ff[`RYAC_FLD_HOUR] && hour_val_ff != time_i.hour) |=> !alarm_o)
        else $error("alarm raised despite enabled hour mismatch");

    // Set beats a simultaneous clear
    set_wins_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (alarm_evt && wr_status && wdata_i[`RYAC_INT_ALARM]) |=> status_ff[`RYAC_INT_ALARM])
        else $error("alarm event lost to a clear");

    // Interrupt line tracks unmasked status
    irq_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_o == |(status_ff & mask_ff))
        else $error("interrupt level wrong");
endmodule // ryac_top
`default_nettype wire

// ---- tb/tb_rtc_year_and_alarm_compare.sv ----
// Purpose: Self-checking bench for the year counter and alarm compare block.
// Assumes: Register port with one-cycle read latency, one clock at 100 MHz.
// Notes:   Expected values come from integer models kept in the bench.
`timescale 1ns/100ps
`default_nettype none
`include "ryac_defs.svh"
module tb_rtc_year_and_alarm_compare
    import ryac_pkg::*;
;
    logic        clk_i          = 1'b0;
    logic        reset_n_i      = 1'b0;
    logic        manual_reset_i = 1'b0;
    logic        wr_i           = 1'b0;
    logic        rd_i           = 1'b0;
    logic        month_carry_i  = 1'b0;
    logic        count_start_i  = 1'b0;
    logic        time_update_i  = 1'b0;
    logic [3:0]  addr_i         = 4'h0;
    ryac_byte_t  wdata_i        = 8'h00;
    ryac_time_s  time_i         = '0;
    ryac_byte_t  rdata_o;
    ryac_byte_t  year_o;
    logic        leap_year_o;
    logic        alarm_o;
    logic        irq_o;
    int          bad_count      = 0;
    int          num_checks     = 0;
    logic [31:0] seed           = 32'h18b5577c;
    ryac_byte_t  rv;

    // Free-running clock
    always #5 clk_i = ~clk_i;

    ryac_top uut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .manual_reset_i(manual_reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .month_carry_i(month_carry_i),
        .count_start_i(count_start_i), .time_i(time_i), .time_update_i(time_update_i),
        .year_o(year_o), .leap_year_o(leap_year_o), .alarm_o(alarm_o), .irq_o(irq_o)
    );

    // Xorshift source of stimulus
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Decimal value to two BCD digits
    function automatic ryac_byte_t bcd(input int v);
        return ryac_byte_t'(((v / 10) << 4) | (v % 10));
    endfunction

    task automatic chk(input ryac_byte_t seen, input ryac_byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input ryac_byte_t d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // One-cycle read, data taken in the following cycle
    task automatic rdchk(input logic [3:0] a, input ryac_byte_t exp);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        rv = rdata_o;
        chk(rv, exp);
    endtask

    // Write then read back with no gap between the strobes
    task automatic wrrd(input logic [3:0] a, input ryac_byte_t d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        rd_i    <= 1'b1;
        @(posedge clk_i);
        rd_i    <= 1'b0;
        @(negedge clk_i);
        rv = rdata_o;
        chk(rv, d);
    endtask

    // Pulse carry and/or time update for one cycle, then settle
    task automatic step(input logic start, input logic carry, input logic upd, input ryac_time_s tv);
        @(posedge clk_i);
        count_start_i <= start;
        month_carry_i <= carry;
        time_update_i <= upd;
        time_i        <= tv;
        @(posedge clk_i);
        count_start_i <= 1'b0;
        month_carry_i <= 1'b0;
        time_update_i <= 1'b0;
        @(negedge clk_i);
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        int         s, mi, h, w, f, ym, m, k;
        logic       exp;
        ryac_time_s t;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // Reset state of enables and interrupt registers
        rdchk(`RYAC_OFS_STATUS, 8'h00);
        rdchk(`RYAC_OFS_MASK, 8'h00);
        chk({7'h0, irq_o}, 8'h00);
        // Alarm values are unknown here, so only the enable bits are looked at
        for (int a = 1; a < 5; a++) begin
            @(posedge clk_i);
            rd_i   <= 1'b1;
            addr_i <= 4'(a);
            @(posedge clk_i);
            rd_i   <= 1'b0;
            @(negedge clk_i);
            chk({7'h0, rdata_o[7]}, 8'h00);
        end
        $display("reset test done");
        // Every year value: readback and leap detection
        for (int y = 0; y < 100; y++) begin
            wr(`RYAC_OFS_YEAR, bcd(y));
            @(negedge clk_i);
            @(negedge clk_i);
            chk({7'h0, leap_year_o}, 8'(y % 4 == 0));
            rdchk(`RYAC_OFS_YEAR, bcd(y));
        end
        wr(4'hf, 8'h11);
        rdchk(4'h7, 8'h00);
        rdchk(`RYAC_OFS_YEAR, bcd(99));
        $display("year register test done");
        // Year stepping with wrap, leap follow-up and year interrupt
        wr(`RYAC_OFS_MASK, 8'h02);
        for (int i = 0; i < 10; i++) begin
            ym = (i == 0) ? 99 : (i == 1) ? 19 : xs() % 100;
            wr(`RYAC_OFS_YEAR, bcd(ym));
            step(1'b1, 1'b1, 1'b0, time_i);
            ym = (ym + 1) % 100;
            chk(year_o, bcd(ym));
            chk({7'h0, irq_o}, 8'h01);
            @(negedge clk_i);
            chk({7'h0, leap_year_o}, 8'(ym % 4 == 0));
            wr(`RYAC_OFS_STATUS, 8'h02);
            @(negedge clk_i);
            chk({7'h0, irq_o}, 8'h00);
        end
        step(1'b0, 1'b1, 1'b0, time_i);
        chk(year_o, bcd(ym));
        @(posedge clk_i);
        wr_i          <= 1'b1;
        addr_i        <= `RYAC_OFS_YEAR;
        wdata_i       <= bcd(7);
        month_carry_i <= 1'b1;
        count_start_i <= 1'b1;
        @(posedge clk_i);
        wr_i          <= 1'b0;
        month_carry_i <= 1'b0;
        count_start_i <= 1'b0;
        @(negedge clk_i);
        ym = 7;
        chk(year_o, bcd(ym));
        chk({7'h0, irq_o}, 8'h00);
        $display("year step test done");
        // All enable combinations, matching and one-field mismatch
        for (m = 0; m < 16; m++) begin
            for (k = 0; k < 2; k++) begin
                s  = xs() % 60;
                mi = xs() % 60;
                h  = xs() % 24;
                w  = xs() % 7;
                f  = xs() % 4;
                wrrd(`RYAC_OFS_SEC, bcd(s) | {m[0], 7'h0});
                wrrd(`RYAC_OFS_MIN, bcd(mi) | {m[1], 7'h0});
                wr(`RYAC_OFS_HOUR, bcd(h) | {m[2], 7'h0} | 8'h40);
                wr(`RYAC_OFS_WKDAY, ryac_byte_t'(w) | {m[3], 7'h0} | 8'h78);
                rdchk(`RYAC_OFS_HOUR, bcd(h) | {m[2], 7'h0});
                rdchk(`RYAC_OFS_WKDAY, ryac_byte_t'(w) | {m[3], 7'h0});
                t.sec   = 7'(bcd(s));
                t.min   = 7'(bcd(mi));
                t.hour  = 6'(bcd(h));
                t.wkday = 3'(w);
                if (k == 1) begin
                    case (f)
                        0: t.sec = 7'(bcd((s + 1) % 60));
                        1: t.min = 7'(bcd((mi + 1) % 60));
                        2: t.hour = 6'(bcd((h + 1) % 24));
                        default: t.wkday = 3'((w + 1) % 7);
                    endcase
                end
                exp = (m != 0) && (k == 0 || !m[f]);
                wr(`RYAC_OFS_MASK, {7'h0, m[0]});
                wr(`RYAC_OFS_STATUS, 8'h03);
                step(1'b0, 1'b0, 1'b1, t);
                chk({7'h0, alarm_o}, {7'h0, exp});
                chk({7'h0, irq_o}, {7'h0, exp & m[0]});
                @(negedge clk_i);
                chk({7'h0, alarm_o}, 8'h00);
                rdchk(`RYAC_OFS_STATUS, {7'h0, exp});
            end
        end
        // Full match again, with a clear of the alarm bit in the same cycle
        t.sec   = 7'(bcd(s));
        t.min   = 7'(bcd(mi));
        t.hour  = 6'(bcd(h));
        t.wkday = 3'(w);
        @(posedge clk_i);
        time_update_i <= 1'b1;
        time_i        <= t;
        wr_i          <= 1'b1;
        addr_i        <= `RYAC_OFS_STATUS;
        wdata_i       <= 8'h01;
        @(posedge clk_i);
        time_update_i <= 1'b0;
        wr_i          <= 1'b0;
        @(negedge clk_i);
        chk({7'h0, alarm_o}, 8'h01);
        rdchk(`RYAC_OFS_STATUS, 8'h01);
        $display("alarm compare test done");
        // Manual reset clears interrupt state, keeps year and alarm setting
        wr(`RYAC_OFS_MASK, 8'h03);
        @(posedge clk_i);
        manual_reset_i <= 1'b1;
        @(posedge clk_i);
        manual_reset_i <= 1'b0;
        rdchk(`RYAC_OFS_MASK, 8'h00);
        rdchk(`RYAC_OFS_STATUS, 8'h00);
        chk({7'h0, irq_o}, 8'h00);
        rdchk(`RYAC_OFS_YEAR, bcd(ym));
        rdchk(`RYAC_OFS_SEC, bcd(s) | 8'h80);
        $display("manual reset test done");
        // Power-on reset in mid-run clears the enables, keeps year and alarm values
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdchk(`RYAC_OFS_YEAR, bcd(ym));
        rdchk(`RYAC_OFS_SEC, bcd(s));
        rdchk(`RYAC_OFS_MIN, bcd(mi));
        rdchk(`RYAC_OFS_HOUR, bcd(h));
        rdchk(`RYAC_OFS_WKDAY, ryac_byte_t'(w));
        // Every value still matches, but no field is enabled any more
        step(1'b0, 1'b0, 1'b1, t);
        chk({7'h0, alarm_o}, 8'h00);
        $display("power-on reset test done");
        tally_and_finish();
    end
endmodule // tb_rtc_year_and_alarm_compare
`default_nettype wire
